// ---- pkg/bcs_map.vh ----
`ifndef BCS_MAP_VH
`define BCS_MAP_VH

// Regulation states
`define BCS_ST_BOOST      2'h0
`define BCS_ST_EQUALISE   2'h1
`define BCS_ST_ABSORB     2'h2
`define BCS_ST_FLOAT      2'h3

// Display screens
`define BCS_SCR_VOLT      1'b0
`define BCS_SCR_STATE     1'b1

// Register byte offsets
`define BCS_A_CTRL        8'h00
`define BCS_A_BOOST_LIMIT_VOLTAGE        8'h04
`define BCS_A_BOOST_RETURN_VOLTAGE        8'h08
`define BCS_A_FLOAT_VOLTAGE        8'h0c
`define BCS_A_ABSORPTION_VOLTAGE        8'h10
`define BCS_A_EQV         8'h14
`define BCS_A_MARGIN      8'h18
`define BCS_A_ADUR        8'h1c
`define BCS_A_EDUR        8'h20
`define BCS_A_BDAYS       8'h24
`define BCS_A_EDAYS       8'h28
`define BCS_A_RECON       8'h2c
`define BCS_A_TOD         8'h30
`define BCS_A_STATUS      8'h34
`define BCS_A_TIMER       8'h38
`define BCS_A_DAYS        8'h3c

// Control bits
`define BCS_CTRL_PER_BOOST 0
`define BCS_CTRL_EQ_EN     1
`define BCS_CTRL_LOCK      2

// Reset values (mV, minutes, days, temperature code)
`define BCS_RST_CTRL      3'h2
`define BCS_RST_BOOST_LIMIT_VOLTAGE      16'h3a98
`define BCS_RST_BOOST_RETURN_VOLTAGE      16'h3070
`define BCS_RST_FLOAT_VOLTAGE      16'h3548
`define BCS_RST_ABSORPTION_VOLTAGE      16'h3840
`define BCS_RST_EQV       16'h3c28
`define BCS_RST_MARGIN    16'h0190
`define BCS_RST_ADUR      16'h003c
`define BCS_RST_EDUR      16'h0078
`define BCS_RST_BDAYS     16'h0000
`define BCS_RST_EDAYS     16'h001e
`define BCS_RST_RECON     16'h0200

// Timing
`define BCS_CLK_HZ        125000000
`define BCS_LONG_PRESS_MS 1000
`define BCS_SEC_PER_MIN   60
`define BCS_MIN_PER_DAY   1440
`define BCS_BOOST_HOLD_MIN 3
`define BCS_BOOST_RET_MIN 10
`define BCS_EQ_START_HOUR 9
`define BCS_EQ_ABANDON_DAYS 4

// AXI responses
`define BCS_RESP_OKAY     2'h0
`define BCS_RESP_SLVERR   2'h2

`endif

// ---- hw/bcs_button.v ----
`timescale 1ns/100ps
`default_nettype none
module bcs_button #(
  parameter [27:0] LONG_CYC = 28'h773_5940
)(
  input  wire        clk,
  input  wire        resetn,
  input  wire        button_n,
  output reg         short_press_ff,
  output reg         long_press_ff
);
  reg        sync1_ff;
  reg        sync2_ff;
  reg [27:0] held_ff;
  reg        long_done_ff;

  // No debounce; contact bounce shows as short presses
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff       <= 1'b1;
      sync2_ff       <= 1'b1;
      held_ff        <= 28'h0;
      long_done_ff   <= 1'b0;
      short_press_ff <= 1'b0;
      long_press_ff  <= 1'b0;
    end else begin
      sync1_ff       <= button_n;
      sync2_ff       <= sync1_ff;
      short_press_ff <= 1'b0;
      long_press_ff  <= 1'b0;
      if (!sync2_ff) begin
        if (!long_done_ff) begin
          if (held_ff == LONG_CYC - 28'h1) begin
            long_press_ff <= 1'b1;
            long_done_ff  <= 1'b1;
          end else begin
            held_ff <= held_ff + 28'h1;
          end
        end
      end else begin
        // Release before the long mark is a short press
        if (held_ff != 28'h0 && !long_done_ff)
          short_press_ff <= 1'b1;
        held_ff      <= 28'h0;
        long_done_ff <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hw/bcs_sequencer.v ----
// Functional notes
// - Boost advances after voltage holds at boost limit for 3 minutes.
// - Below boost return voltage over 10 minutes returns to boost.
// - Periodic boost enters boost after programmed days, whatever the voltage.
// - Long press on voltage screen shows the regulation state code.
// - On state screen, long press advances state; short press returns.
// - Equalise duration zero skips equalise, except a pending one entered from absorb or float.
// - Absorption duration zero skips absorption.
// - Boost/float show voltage; on state screen, equalise/absorb show elapsed state timer.
// - Equalise or absorb timer at its duration advances the state.
// - Equalise holds at equalise voltage until its duration accumulates.
// - Equalise is due every interval days, starting at 9am.
// - Equalise is abandoned after 4 days in that state.
// - Absorb regulates to absorption voltage; timer pauses when low.
// - Absorb timer counts only above absorption voltage minus margin.
// - Float charges below float voltage, stops once regained.
// - Boost passes all charge current without limiting.
// - Voltage screen is selected after power-up.
// - Lockout bit blocks any further change of settings.
// - Overloaded load switch reconnects once switch temperature falls.
`include "bcs_map.vh"
`timescale 1ns/100ps
`default_nettype none
module bcs_sequencer #(
  parameter [27:0] CYC_PER_SEC    = `BCS_CLK_HZ,
  parameter [27:0] LONG_PRESS_CYC = `BCS_CLK_HZ / 1000 * `BCS_LONG_PRESS_MS
)(
  input  wire        clk,
  input  wire        resetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        button_n,
  input  wire [15:0] batt_mv,
  input  wire        load_overload,
  input  wire [11:0] switch_temp,
  output reg  [1:0]  reg_state_ff,
  output reg         charge_en_ff,
  output reg         full_current_ff,
  output reg         screen_ff,
  output reg  [15:0] disp_value_ff,
  output reg         load_on_ff
);
  localparam [9:0]  HOLD_S = `BCS_BOOST_HOLD_MIN * `BCS_SEC_PER_MIN;
  localparam [9:0]  RET_S  = `BCS_BOOST_RET_MIN * `BCS_SEC_PER_MIN;
  localparam [10:0] EQ_MIN = `BCS_EQ_START_HOUR * `BCS_SEC_PER_MIN;
  localparam [10:0] DAY_M1 = `BCS_MIN_PER_DAY - 1;
  localparam [5:0]  MIN_M1 = `BCS_SEC_PER_MIN - 1;
  localparam [7:0]  EQ_ABN = `BCS_EQ_ABANDON_DAYS;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function [15:0] sat_sub;
    input [15:0] a;
    input [15:0] b;
    begin
      sat_sub = (a > b) ? a - b : 16'h0;
    end
  endfunction

  // Byte lanes of a 16-bit setting
  function [15:0] lane16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  strb;
    begin
      lane16 = {strb[1] ? nw[15:8] : old[15:8],
                strb[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  function [1:0] next_state;
    input [1:0] st;
    input       eq_ok;
    input       abs_ok;
    begin
      case (st)
        `BCS_ST_BOOST:    next_state = eq_ok ? `BCS_ST_EQUALISE :
                                       abs_ok ? `BCS_ST_ABSORB :
                                       `BCS_ST_FLOAT;
        `BCS_ST_EQUALISE: next_state = abs_ok ? `BCS_ST_ABSORB :
                                       `BCS_ST_FLOAT;
        `BCS_ST_ABSORB:   next_state = `BCS_ST_FLOAT;
        default:          next_state = `BCS_ST_BOOST;
      endcase
    end
  endfunction

  // Settings
  reg [2:0]  ctrl_ff;
  reg [15:0] boost_limit_voltage_ff;
  reg [15:0] boost_return_voltage_ff;
  reg [15:0] float_voltage_ff;
  reg [15:0] absorption_voltage_ff;
  reg [15:0] equalise_voltage_ff;
  reg [15:0] regulation_margin_ff;
  reg [15:0] absorption_duration_ff;
  reg [15:0] equalise_duration_ff;
  reg [15:0] boost_interval_days_ff;
  reg [15:0] equalise_interval_days_ff;
  reg [15:0] recon_temp_ff;
  // Bus state
  reg [7:0]  awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  reg        aw_got_ff;
  reg        w_got_ff;
  reg [31:0] rd_mux;
  // Time base
  reg [27:0] sec_cnt_ff;
  reg [5:0]  sec_of_min_ff;
  reg [10:0] tod_ff;
  // Sequencer
  reg [9:0]  hold_s_ff;
  reg [9:0]  low_s_ff;
  reg [5:0]  st_sec_ff;
  reg [15:0] st_min_ff;
  reg [7:0]  eq_days_ff;
  reg [7:0]  boost_days_ff;
  reg [7:0]  eq_day_cnt_ff;
  reg        eq_pending_ff;
  reg        go;
  reg [1:0]  dest;

  wire short_press;
  wire long_press;

  bcs_button #(
    .LONG_CYC       (LONG_PRESS_CYC)
  ) u_button (
    .clk            (clk),
    .resetn         (resetn),
    .button_n       (button_n),
    .short_press_ff (short_press),
    .long_press_ff  (long_press)
  );

  wire wr_fire  = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire locked   = ctrl_ff[`BCS_CTRL_LOCK];
  wire is_set   = awaddr_ff <= `BCS_A_RECON;
  wire wr_set   = wr_fire & is_set & ~locked;
  wire wr_tod   = wr_fire & (awaddr_ff == `BCS_A_TOD);
  wire [31:0] wv = merge(32'h0, wdata_ff, wstrb_ff);
  wire [15:0] wd16 = wdata_ff[15:0];
  wire [1:0]  ws2  = wstrb_ff[1:0];

  // Write channel: address and data taken in either order
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BCS_RESP_OKAY;
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awaddr_ff     <= 8'h0;
      wdata_ff      <= 32'h0;
      wstrb_ff      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff     <= {s_axi_awaddr[7:2], 2'h0};
        aw_got_ff     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        w_got_ff     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Locked settings and read-only words answer with an error
        s_axi_bresp  <= (wr_set | wr_tod) ? `BCS_RESP_OKAY :
                        `BCS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Setting registers; strobes only change the addressed bytes
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff                   <= `BCS_RST_CTRL;
      boost_limit_voltage_ff    <= `BCS_RST_BOOST_LIMIT_VOLTAGE;
      boost_return_voltage_ff   <= `BCS_RST_BOOST_RETURN_VOLTAGE;
      float_voltage_ff          <= `BCS_RST_FLOAT_VOLTAGE;
      absorption_voltage_ff     <= `BCS_RST_ABSORPTION_VOLTAGE;
      equalise_voltage_ff       <= `BCS_RST_EQV;
      regulation_margin_ff      <= `BCS_RST_MARGIN;
      absorption_duration_ff    <= `BCS_RST_ADUR;
      equalise_duration_ff      <= `BCS_RST_EDUR;
      boost_interval_days_ff    <= `BCS_RST_BDAYS;
      equalise_interval_days_ff <= `BCS_RST_EDAYS;
      recon_temp_ff             <= `BCS_RST_RECON;
    end else if (wr_set) begin
      case (awaddr_ff)
        `BCS_A_CTRL: ctrl_ff <= ws2[0] ? wdata_ff[2:0] : ctrl_ff;
        `BCS_A_BOOST_LIMIT_VOLTAGE: boost_limit_voltage_ff <=
          lane16(boost_limit_voltage_ff, wd16, ws2);
        `BCS_A_BOOST_RETURN_VOLTAGE: boost_return_voltage_ff <=
          lane16(boost_return_voltage_ff, wd16, ws2);
        `BCS_A_FLOAT_VOLTAGE: float_voltage_ff <=
          lane16(float_voltage_ff, wd16, ws2);
        `BCS_A_ABSORPTION_VOLTAGE: absorption_voltage_ff <=
          lane16(absorption_voltage_ff, wd16, ws2);
        `BCS_A_EQV: equalise_voltage_ff <=
          lane16(equalise_voltage_ff, wd16, ws2);
        `BCS_A_MARGIN: regulation_margin_ff <=
          lane16(regulation_margin_ff, wd16, ws2);
        `BCS_A_ADUR: absorption_duration_ff <=
          lane16(absorption_duration_ff, wd16, ws2);
        `BCS_A_EDUR: equalise_duration_ff <=
          lane16(equalise_duration_ff, wd16, ws2);
        `BCS_A_BDAYS: boost_interval_days_ff <=
          lane16(boost_interval_days_ff, wd16, ws2);
        `BCS_A_EDAYS: equalise_interval_days_ff <=
          lane16(equalise_interval_days_ff, wd16, ws2);
        default: recon_temp_ff <= lane16(recon_temp_ff, wd16, ws2);
      endcase
    end
  end

  // Read data
  always @* begin
    case ({s_axi_araddr[7:2], 2'h0})
      `BCS_A_CTRL:   rd_mux = {29'h0, ctrl_ff};
      `BCS_A_BOOST_LIMIT_VOLTAGE:   rd_mux = {16'h0, boost_limit_voltage_ff};
      `BCS_A_BOOST_RETURN_VOLTAGE:   rd_mux = {16'h0, boost_return_voltage_ff};
      `BCS_A_FLOAT_VOLTAGE:   rd_mux = {16'h0, float_voltage_ff};
      `BCS_A_ABSORPTION_VOLTAGE:   rd_mux = {16'h0, absorption_voltage_ff};
      `BCS_A_EQV:    rd_mux = {16'h0, equalise_voltage_ff};
      `BCS_A_MARGIN: rd_mux = {16'h0, regulation_margin_ff};
      `BCS_A_ADUR:   rd_mux = {16'h0, absorption_duration_ff};
      `BCS_A_EDUR:   rd_mux = {16'h0, equalise_duration_ff};
      `BCS_A_BDAYS:  rd_mux = {16'h0, boost_interval_days_ff};
      `BCS_A_EDAYS:  rd_mux = {16'h0, equalise_interval_days_ff};
      `BCS_A_RECON:  rd_mux = {16'h0, recon_temp_ff};
      `BCS_A_TOD:    rd_mux = {21'h0, tod_ff};
      `BCS_A_STATUS: rd_mux = {25'h0, eq_pending_ff, load_on_ff,
                               full_current_ff, charge_en_ff, screen_ff,
                               reg_state_ff};
      `BCS_A_TIMER:  rd_mux = {10'h0, st_sec_ff, st_min_ff};
      default:       rd_mux = {8'h0, eq_days_ff, eq_day_cnt_ff, boost_days_ff};
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `BCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= `BCS_RESP_OKAY;
      s_axi_rvalid  <= 1'b1;
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Time base: seconds, minutes, time of day
  wire sec_tick = (sec_cnt_ff == CYC_PER_SEC - 28'h1);
  wire min_tick = sec_tick & (sec_of_min_ff == MIN_M1);
  wire day_tick = min_tick & (tod_ff == DAY_M1);
  wire at_9am   = min_tick & (tod_ff == EQ_MIN - 11'h1);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sec_cnt_ff    <= 28'h0;
      sec_of_min_ff <= 6'h0;
      tod_ff        <= 11'h0;
    end else begin
      sec_cnt_ff <= sec_tick ? 28'h0 : sec_cnt_ff + 28'h1;
      if (sec_tick)
        sec_of_min_ff <= (sec_of_min_ff == MIN_M1) ? 6'h0 :
                         sec_of_min_ff + 6'h1;
      if (wr_tod)
        tod_ff <= (wv[10:0] > DAY_M1) ? 11'h0 : wv[10:0];
      else if (min_tick)
        tod_ff <= (tod_ff == DAY_M1) ? 11'h0 : tod_ff + 11'h1;
    end
  end

  wire eq_ok   = equalise_duration_ff != 16'h0;
  wire abs_ok  = absorption_duration_ff != 16'h0;
  wire boost_due = ctrl_ff[`BCS_CTRL_PER_BOOST] &
                   (boost_interval_days_ff != 16'h0) &
                   ({8'h0, boost_days_ff} >= boost_interval_days_ff);
  wire abs_cnt = (reg_state_ff == `BCS_ST_ABSORB) &
                 (batt_mv > sat_sub(absorption_voltage_ff,
                                    regulation_margin_ff));
  wire eq_cnt  = (reg_state_ff == `BCS_ST_EQUALISE) &
                 (batt_mv > sat_sub(equalise_voltage_ff,
                                    regulation_margin_ff));
  wire low_v   = batt_mv < boost_return_voltage_ff;

  // Transition choice; the button wins over automatic moves
  always @* begin
    go   = 1'b0;
    dest = reg_state_ff;
    if (long_press && screen_ff == `BCS_SCR_STATE) begin
      go   = 1'b1;
      dest = next_state(reg_state_ff, eq_ok, abs_ok);
    end else if (reg_state_ff != `BCS_ST_BOOST &&
                 (low_s_ff > RET_S || boost_due)) begin
      go   = 1'b1;
      dest = `BCS_ST_BOOST;
    end else if (eq_pending_ff && (reg_state_ff == `BCS_ST_ABSORB ||
                                   reg_state_ff == `BCS_ST_FLOAT)) begin
      go   = 1'b1;
      dest = `BCS_ST_EQUALISE;
    end else begin
      case (reg_state_ff)
        `BCS_ST_BOOST: if (hold_s_ff >= HOLD_S) begin
          go   = 1'b1;
          dest = next_state(reg_state_ff, eq_pending_ff & eq_ok,
                            abs_ok);
        end
        `BCS_ST_EQUALISE: if (st_min_ff >= equalise_duration_ff ||
                              eq_days_ff >= EQ_ABN) begin
          go   = 1'b1;
          dest = next_state(reg_state_ff, 1'b0, abs_ok);
        end
        `BCS_ST_ABSORB: if (st_min_ff >= absorption_duration_ff) begin
          go   = 1'b1;
          dest = `BCS_ST_FLOAT;
        end
        default: go = 1'b0;
      endcase
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_state_ff  <= `BCS_ST_BOOST;
      hold_s_ff     <= 10'h0;
      low_s_ff      <= 10'h0;
      st_sec_ff     <= 6'h0;
      st_min_ff     <= 16'h0;
      eq_days_ff    <= 8'h0;
      boost_days_ff <= 8'h0;
      eq_day_cnt_ff <= 8'h0;
      eq_pending_ff <= 1'b0;
    end else begin
      if (go) begin
        reg_state_ff <= dest;
        hold_s_ff    <= 10'h0;
        st_sec_ff    <= 6'h0;
        st_min_ff    <= 16'h0;
        eq_days_ff   <= 8'h0;
        low_s_ff     <= 10'h0;
      end else begin
        // Timers pause, not clear, while voltage sags
        if (sec_tick && (abs_cnt || eq_cnt)) begin
          st_sec_ff <= (st_sec_ff == MIN_M1) ? 6'h0 : st_sec_ff + 6'h1;
          if (st_sec_ff == MIN_M1 && st_min_ff != 16'hffff)
            st_min_ff <= st_min_ff + 16'h1;
        end
        if (reg_state_ff == `BCS_ST_BOOST &&
            batt_mv >= boost_limit_voltage_ff) begin
          if (sec_tick && hold_s_ff != HOLD_S)
            hold_s_ff <= hold_s_ff + 10'h1;
        end else begin
          hold_s_ff <= 10'h0;
        end
        // Short dips restart the count
        if (reg_state_ff != `BCS_ST_BOOST && low_v) begin
          if (sec_tick && low_s_ff <= RET_S)
            low_s_ff <= low_s_ff + 10'h1;
        end else begin
          low_s_ff <= 10'h0;
        end
        if (reg_state_ff == `BCS_ST_EQUALISE && day_tick &&
            eq_days_ff != EQ_ABN)
          eq_days_ff <= eq_days_ff + 8'h1;
      end
      if (go && dest == `BCS_ST_BOOST)
        boost_days_ff <= 8'h0;
      else if (day_tick && boost_days_ff != 8'hff)
        boost_days_ff <= boost_days_ff + 8'h1;
      if (go && dest == `BCS_ST_EQUALISE) begin
        eq_day_cnt_ff <= 8'h0;
        eq_pending_ff <= 1'b0;
      end else begin
        if (day_tick && eq_day_cnt_ff != 8'hff)
          eq_day_cnt_ff <= eq_day_cnt_ff + 8'h1;
        if (at_9am && ctrl_ff[`BCS_CTRL_EQ_EN] && eq_ok &&
            {8'h0, eq_day_cnt_ff} >= equalise_interval_days_ff)
          eq_pending_ff <= 1'b1;
      end
    end
  end

  // Charge demand, display and load switch
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      charge_en_ff    <= 1'b0;
      full_current_ff <= 1'b0;
      screen_ff       <= `BCS_SCR_VOLT;
      disp_value_ff   <= 16'h0;
      load_on_ff      <= 1'b1;
    end else begin
      case (reg_state_ff)
        `BCS_ST_BOOST:    charge_en_ff <= 1'b1;
        `BCS_ST_EQUALISE: charge_en_ff <= batt_mv < equalise_voltage_ff;
        `BCS_ST_ABSORB:   charge_en_ff <= batt_mv < absorption_voltage_ff;
        default:          charge_en_ff <= batt_mv < float_voltage_ff;
      endcase
      full_current_ff <= reg_state_ff == `BCS_ST_BOOST;
      if (screen_ff == `BCS_SCR_VOLT && long_press)
        screen_ff <= `BCS_SCR_STATE;
      else if (screen_ff == `BCS_SCR_STATE && short_press)
        screen_ff <= `BCS_SCR_VOLT;
      // State code rides on reg_state_ff beside the value
      if (screen_ff == `BCS_SCR_STATE &&
          (reg_state_ff == `BCS_ST_EQUALISE ||
           reg_state_ff == `BCS_ST_ABSORB))
        disp_value_ff <= st_min_ff;
      else
        disp_value_ff <= batt_mv;
      if (load_overload)
        load_on_ff <= 1'b0;
      else if (!load_on_ff && {4'h0, switch_temp} <= recon_temp_ff)
        load_on_ff <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- dv/bcs_seq_monitor.sv ----
`include "bcs_map.vh"
`timescale 1ns/100ps
`default_nettype none
module bcs_seq_monitor #(
  parameter [15:0] FLOAT_MV = `BCS_RST_FLOAT_VOLTAGE
)(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        button_n,
  input wire logic [15:0] batt_mv,
  input wire logic [1:0]  reg_state_ff,
  input wire logic        charge_en_ff,
  input wire logic        full_current_ff,
  input wire logic        screen_ff,
  input wire logic [15:0] disp_value_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic run_ff;
  wire  in_boost = reg_state_ff == `BCS_ST_BOOST;
  wire  in_float = reg_state_ff == `BCS_ST_FLOAT;
  wire  volt_st  = in_boost || in_float;
  // Outputs settle one edge after release, so skip that edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) run_ff <= 1'b0;
    else run_ff <= 1'b1;
  end
  sequence s_fl_low;
    in_float && batt_mv < FLOAT_MV;
  endsequence
  sequence s_fl_ok;
    in_float && batt_mv >= FLOAT_MV;
  endsequence
  a_reset_view: assert property ($rose(resetn) |-> !screen_ff && in_boost)
    else $error("screen or state wrong after reset");
  a_full_boost: assert property (run_ff && $stable(reg_state_ff)
    |-> full_current_ff == in_boost) else $error("full current flag wrong");
  a_boost_charge: assert property (run_ff && in_boost && $past(in_boost)
    |-> charge_en_ff) else $error("charge off in boost");
  a_disp_volt: assert property (run_ff && volt_st && $past(volt_st)
    |-> disp_value_ff == $past(batt_mv)) else $error("display not voltage");
  a_float_on: assert property (s_fl_low [*2] |-> charge_en_ff)
    else $error("no charge below float voltage");
  a_float_off: assert property (s_fl_ok [*2] |-> !charge_en_ff)
    else $error("charging above float voltage");
  a_state_view: assert property ($rose(screen_ff)
    |-> !$past(button_n, 5) && $stable(reg_state_ff))
    else $error("state screen without long press");
  a_short_back: assert property ($fell(screen_ff) |-> $stable(reg_state_ff))
    else $error("state changed on return to voltage");
endmodule
`default_nettype wire

// ---- dv/bcs_user_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module bcs_user_model (
  input  wire logic        clk,
  output var  logic        button_n,
  output var  logic [15:0] batt_mv
);
  initial begin
    button_n = 1'b1;
    batt_mv  = 16'h3200;
  end
  // Clean press; the pause after lets the screen logic settle
  task automatic press(input int n);
    @(posedge clk);
    button_n <= 1'b0;
    repeat (n) @(posedge clk);
    button_n <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
  task automatic set_mv(input logic [15:0] v);
    @(posedge clk);
    batt_mv <= v;
  endtask
endmodule
`default_nettype wire

// ---- dv/battery_charge_state_sequencer_tb.sv ----
`include "bcs_map.vh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, g, e) begin total_checks++; if ((g) !== (e)) begin \
  fails++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module battery_charge_state_sequencer_tb;
  logic        clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, button_n;
  logic        load_overload, charge_en_ff, full_current_ff, screen_ff;
  logic        load_on_ff;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, reg_state_ff;
  logic [15:0] batt_mv, disp_value_ff;
  logic [11:0] switch_temp;
  int          fails, total_checks, cyc;
  bcs_sequencer #(.CYC_PER_SEC(28'ha), .LONG_PRESS_CYC(28'h8)) DUT (.*);
  bcs_user_model user (.clk(clk), .button_n(button_n), .batt_mv(batt_mv));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        dd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK("bresp", s_axi_bresp, r)
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
  endtask
  task automatic t_boost();
    repeat (2) @(posedge clk);
    `CHK("screen", screen_ff, `BCS_SCR_VOLT)
    `CHK("full", full_current_ff, 1'b1)
    axw(`BCS_A_ADUR, 32'h1, `BCS_RESP_OKAY);
    user.set_mv(16'h3b00);
    repeat (1700) @(posedge clk);
    `CHK("hold", reg_state_ff, `BCS_ST_BOOST)
    repeat (200) @(posedge clk);
    `CHK("absorb", reg_state_ff, `BCS_ST_ABSORB)
    $display("boost test done");
  endtask
  task automatic t_absorb();
    user.press(20);
    `CHK("timer", disp_value_ff, 16'h0)
    user.press(3);
    user.set_mv(16'h35e8);
    repeat (700) @(posedge clk);
    `CHK("paused", reg_state_ff, `BCS_ST_ABSORB)
    user.set_mv(16'h3b00);
    repeat (700) @(posedge clk);
    `CHK("float", reg_state_ff, `BCS_ST_FLOAT)
    $display("absorb test done");
  endtask
  task automatic t_float();
    user.set_mv(16'h3200);
    repeat (3) @(posedge clk);
    `CHK("chg on", charge_en_ff, 1'b1)
    `CHK("disp", disp_value_ff, 16'h3200)
    user.set_mv(16'h3600);
    repeat (3) @(posedge clk);
    `CHK("chg off", charge_en_ff, 1'b0)
    $display("float test done");
  endtask
  task automatic t_button();
    user.press(20);
    `CHK("view", screen_ff, `BCS_SCR_STATE)
    user.press(20);
    `CHK("adv", reg_state_ff, `BCS_ST_BOOST)
    axr(`BCS_A_STATUS);
    `CHK("status", rd[2:0], {`BCS_SCR_STATE, `BCS_ST_BOOST})
    user.press(3);
    `CHK("back", screen_ff, `BCS_SCR_VOLT)
    `CHK("kept", reg_state_ff, `BCS_ST_BOOST)
    $display("button test done");
  endtask
  task automatic t_skip();
    axw(`BCS_A_EDUR, 32'h0, `BCS_RESP_OKAY);
    axw(`BCS_A_ADUR, 32'h0, `BCS_RESP_OKAY);
    user.press(20);
    user.press(20);
    `CHK("skip", reg_state_ff, `BCS_ST_FLOAT)
    user.press(3);
    $display("skip test done");
  endtask
  task automatic t_return();
    user.set_mv(16'h2ee0);
    repeat (5900) @(posedge clk);
    `CHK("dip", reg_state_ff, `BCS_ST_FLOAT)
    repeat (300) @(posedge clk);
    `CHK("ret", reg_state_ff, `BCS_ST_BOOST)
    $display("return test done");
  endtask
  task automatic t_period();
    axw(`BCS_A_BDAYS, 32'h1, `BCS_RESP_OKAY);
    axw(`BCS_A_CTRL, 32'h3, `BCS_RESP_OKAY);
    user.set_mv(16'h3600);
    user.press(20);
    user.press(20);
    user.press(3);
    `CHK("no day", reg_state_ff, `BCS_ST_FLOAT)
    axw(`BCS_A_TOD, 32'h59f, `BCS_RESP_OKAY);
    repeat (700) @(posedge clk);
    `CHK("period", reg_state_ff, `BCS_ST_BOOST)
    $display("period test done");
  endtask
  task automatic t_lock();
    axw(8'h40, 32'h0, `BCS_RESP_SLVERR);
    s_axi_wstrb <= 4'h1;
    axw(`BCS_A_MARGIN, 32'h1234, `BCS_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axr(`BCS_A_MARGIN);
    `CHK("strb", rd, 32'h134)
    axw(`BCS_A_CTRL, 32'h6, `BCS_RESP_OKAY);
    axw(`BCS_A_ADUR, 32'h5, `BCS_RESP_SLVERR);
    axr(`BCS_A_ADUR);
    `CHK("locked", rd, 32'h0)
    $display("lock test done");
  endtask
  task automatic t_load();
    load_overload <= 1'b1;
    switch_temp <= 12'h300;
    repeat (2) @(posedge clk);
    `CHK("ld off", load_on_ff, 1'b0)
    load_overload <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("ld hot", load_on_ff, 1'b0)
    switch_temp <= 12'h100;
    repeat (2) @(posedge clk);
    `CHK("ld on", load_on_ff, 1'b1)
    $display("load test done");
  endtask
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_boost();
    t_absorb();
    t_float();
    t_button();
    t_skip();
    t_return();
    t_period();
    t_lock();
    t_load();
    conclude();
  end
endmodule
bind bcs_sequencer bcs_seq_monitor mon (.*);
`default_nettype wire
